/* File: bench/fsq_engine_model.sv */
/*
  Message engine model: accepts message indices, pulses msg_done.
  Assumes the scheduler's valid/ready stream on sys_clk.
*/
`default_nettype none
module fsq_engine_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic msg_valid,
  input  wire logic slow,
  output logic      msg_ready,
  output logic      msg_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_q;
  logic [2:0] cnt_q;
  // Ready drops while busy, so a slow engine backs up the buffer.
  assign msg_ready = rst_n && !busy_q;
  always_ff @(posedge sys_clk) begin
    msg_done <= rst_n && busy_q && (cnt_q == 3'h0);
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 3'h0;
    end else if (busy_q) begin
      busy_q <= (cnt_q != 3'h0);
      cnt_q  <= cnt_q - 3'h1;
    end else if (msg_valid) begin
      busy_q <= 1'b1;
      cnt_q  <= slow ? 3'h7 : 3'h0;
    end
  end
endmodule : fsq_engine_model
`default_nettype wire

/* File: bench/tb_bc_rt_frame_scheduler.sv */
/*
  Self-checking bench for the frame scheduler.
  Assumes the engine model above; bench drives the message context.
*/
`default_nettype none
`define CHK(n, e, a) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("Error %s exp %0h got %0h", n, e, a); \
  end \
end
module tb_bc_rt_frame_scheduler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DC = 20;
  logic        sys_clk, rst_n, reg_wr, reg_rd, msg_ready, msg_done;
  logic        msg_start, rx_valid, slow, msg_valid, rt_sim, mem_we;
  logic        mode_is_code, mode_has_data, mode_unsupported, frame_busy;
  logic [13:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, msg_index, d, tbl[32];
  logic [1:0]  msg_kind;
  logic [15:0] msg_base, cmd_word, rx_word, mem_addr, mem_wdata, aq[$], wq[$];
  int          mismatches, checks_done, seed, cyc, frames, taken, f0, f1;
  int          nidx, icnt;
  fsq_frame_sched #(.DEAD_CYC(DC)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_index(msg_index), .msg_done(msg_done), .msg_kind(msg_kind),
    .msg_base(msg_base), .cmd_word(cmd_word), .msg_start(msg_start),
    .rx_valid(rx_valid), .rx_word(rx_word), .rt_sim(rt_sim),
    .mode_is_code(mode_is_code), .mode_has_data(mode_has_data),
    .mode_unsupported(mode_unsupported), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .frame_busy(frame_busy));
  fsq_engine_model eng (.sys_clk(sys_clk), .rst_n(rst_n),
    .msg_valid(msg_valid), .slow(slow), .msg_ready(msg_ready),
    .msg_done(msg_done));
  // ----------------------------------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    slow <= 1'($random(seed));
    if (mem_we) begin
      aq.push_back(mem_addr);
      wq.push_back(mem_wdata);
    end
    if (msg_valid && msg_ready) begin
      `CHK("index", 8'(nidx), msg_index)
      nidx = (nidx + 1) % icnt;
      taken++;
      if (msg_index == 8'h00) begin
        frames++;
        f0 = f1;
        f1 = cyc;
      end
    end
  end
  function automatic int lo_gap(input int f);
    return f * fsq_pkg::RES_UNIT_NS / fsq_pkg::CLK_PERIOD_NS - 4;
  endfunction : lo_gap
  function automatic logic win(input int f);
    return f1 - f0 >= lo_gap(f) && f1 - f0 <= lo_gap(f) + DC + 140;
  endfunction : win
  function automatic logic [15:0] cur(input logic [1:0] k,
                                      input logic [15:0] b, input int i);
    return b + ((k == 2'h2) ? 16'h3 : 16'h2) + 16'(i);
  endfunction : cur
  task automatic wr(input logic [13:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic store(input logic [1:0] k, input logic [15:0] b, input int n);
    logic [15:0] w[$];
    aq.delete();
    wq.delete();
    @(posedge sys_clk);
    msg_kind <= k;
    msg_base <= b;
    msg_start <= 1'b1;
    @(posedge sys_clk);
    msg_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      w.push_back(16'($random(seed)));
      rx_word <= w[i];
      rx_valid <= 1'b1;
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("stores", (k == 2'h1) ? 0 : n, aq.size())
    for (int i = 0; i < aq.size(); i++) begin
      `CHK("st_addr", cur(k, b, i), aq[i])
      `CHK("st_data", w[i], wq[i])
    end
  endtask : store
  task automatic run(input logic [7:0] st, lc, ft, input int n);
    wr(fsq_pkg::INSTR_CNT_OFF, 8'(n));
    wr(fsq_pkg::LOOP_CNT_OFF, lc);
    wr(fsq_pkg::RES_LO_OFF, 8'h01);
    wr(fsq_pkg::RES_HI_OFF, 8'h00);
    wr(fsq_pkg::FT_LO_OFF, ft);
    wr(fsq_pkg::FT_HI_OFF, 8'h00);
    frames = 0;
    taken = 0;
    nidx = 0;
    icnt = n;
    wr(fsq_pkg::START_OFF, st);
  endtask : run
  task automatic wait_idle();
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 20000 && frame_busy !== 1'b0; i++) @(posedge sys_clk);
    `CHK("idle", 1'b0, frame_busy)
  endtask : wait_idle
  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    #300000;
    mismatches++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 13258;
    icnt = 1;
    {rst_n, reg_wr, reg_rd, msg_start, rx_valid} = 5'h00;
    {reg_addr, reg_wdata, msg_kind, msg_base, cmd_word, rx_word} = '0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(fsq_pkg::BOARD_STAT_OFF, d);
    `CHK("halted", fsq_pkg::BOARD_IDLE, d)
    rd(14'h3500, d);
    `CHK("unmapped", 8'h00, d)
    for (int t = 0; t < 32; t++) begin
      tbl[t] = 8'($random(seed));
      wr(fsq_pkg::ACT_TBL_BASE + 14'(t), tbl[t]);
    end
    for (int t = 0; t < 32; t++) begin
      rd(fsq_pkg::ACT_TBL_BASE + 14'(t), d);
      `CHK("table", {7'h00, tbl[t][0]}, d)
      @(posedge sys_clk);
      cmd_word <= {5'(t), 11'h420};
      @(negedge sys_clk);
      `CHK("rt_sim", tbl[t][0], rt_sim)
    end
    for (int c = 0; c < 64; c++) begin
      @(posedge sys_clk);
      cmd_word <= {5'h01, 1'b1, c[5] ? 5'h1F : 5'h00, 5'(c)};
      @(negedge sys_clk);
      `CHK("mode", 1'b1, mode_is_code)
      `CHK("mode_data", c[4], mode_has_data)
      `CHK("unsup", (c % 32 == 20 || c % 32 == 21), mode_unsupported)
    end
    wr(fsq_pkg::ACT_TBL_BASE + 14'h5, 8'h00);
    wr(fsq_pkg::ACT_TBL_BASE + 14'h6, 8'hFF);
    @(posedge sys_clk);
    cmd_word <= 16'h2C23;
    @(negedge sys_clk);
    `CHK("not_mode", 1'b0, mode_is_code)
    store(2'h0, 16'h0100, 4);
    store(2'h2, 16'h0140, 3);
    @(posedge sys_clk);
    cmd_word <= 16'h3023;
    store(2'h1, 16'h0180, 2);
    run(8'h01, 8'h00, 8'h00, 3);
    wait_idle();
    `CHK("one_pass", 3, taken)
    rd(fsq_pkg::MSG_STATUS_OFF, d);
    `CHK("complete", 1'b1, d[0])
    wr(fsq_pkg::MSG_STATUS_OFF, 8'h01);
    rd(fsq_pkg::MSG_STATUS_OFF, d);
    `CHK("cleared", 1'b0, d[0])
    run(8'h03, 8'h02, 8'h20, 2);
    wait_idle();
    `CHK("loops", 2, frames)
    `CHK("period", 1'b1, win(32))
    run(8'h03, 8'h02, 8'h00, 2);
    wait_idle();
    `CHK("dead", 1'b1, f1 - f0 >= DC && f1 - f0 < 200)
    run(8'h03, 8'h00, 8'h10, 2);
    for (int i = 0; i < 20000 && frames < 4; i++) @(posedge sys_clk);
    `CHK("reload", 1'b1, win(16))
    wr(fsq_pkg::START_OFF, 8'h00);
    wait_idle();
    `CHK("cont", 1'b1, frames >= 4)
    // Reset in the middle of a continuous run must leave everything idle.
    run(8'h03, 8'h00, 8'h10, 1);
    repeat (40) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(fsq_pkg::BOARD_STAT_OFF, d);
    `CHK("rst_halt", fsq_pkg::BOARD_IDLE, d)
    rd(fsq_pkg::ACT_TBL_BASE + 14'h6, d);
    `CHK("rst_tbl", 8'h00, d)
    `CHK("rst_busy", 1'b0, frame_busy)
    summarize();
  end
endmodule : tb_bc_rt_frame_scheduler
`default_nettype wire

/* File: core/fsq_buf2.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a synchronous active-low reset on the system clock.
*/
`default_nettype none
module fsq_buf2 #(
  parameter int W = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  fsq_stream_if.snk in_s,
  fsq_stream_if.src out_s
);
  logic [W-1:0] slot_q [2];
  logic         rd_ptr_q;
  logic         wr_ptr_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  // Ready depends only on the fill count, so a stalled sink stops the source.
  assign in_s.ready  = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data  = slot_q[rd_ptr_q];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_s.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop)  rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  no_overflow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_q == 2'h2 && !pop |=> cnt_q == 2'h2 && $stable(slot_q[0]) &&
      $stable(slot_q[1]))
    else $error("buffer overwrote a word while full");
  hold_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("buffer output changed while stalled");
endmodule : fsq_buf2
`default_nettype wire

/* File: core/fsq_frame_sched.sv */
/*
  Frame scheduler: register file, active-terminal table, frame timing,
  message issue through a two-entry buffer, storage cursor for words
  returned by real terminals, and mode-code decode.
  Assumes a message engine outside that takes message indices, reports
  words received from the bus and pulses msg_done per message.
*/
// Our own choice: the address-and-strobe port.
`default_nettype none
module fsq_frame_sched #(
  parameter int DEAD_CYC = fsq_pkg::DEAD_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             msg_valid,
  input  wire logic        msg_ready,
  output logic      [7:0]  msg_index,
  input  wire logic        msg_done,
  input  wire logic [1:0]  msg_kind,
  input  wire logic [15:0] msg_base,
  input  wire logic [15:0] cmd_word,
  input  wire logic        msg_start,
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_word,
  output logic             rt_sim,
  output logic             mode_is_code,
  output logic             mode_has_data,
  output logic             mode_unsupported,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic             frame_busy
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (DEAD_CYC < 1 || DEAD_CYC > 65535) begin : g_bad_dead
    $error("DEAD_CYC must lie in 1..65535");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_mode(input logic [15:0] w);
    return (w[9:5] == 5'h00) || (w[9:5] == 5'h1F);
  endfunction : is_mode

  function automatic logic [15:0] pair16(input logic [7:0] hi,
                                         input logic [7:0] lo);
    return {hi, lo};
  endfunction : pair16

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] act_tbl_q [32];
  logic [7:0] loop_cnt_q;
  logic [7:0] instr_cnt_q;
  logic [7:0] res_lo_q;
  logic [7:0] res_hi_q;
  logic [7:0] ft_lo_q;
  logic [7:0] ft_hi_q;
  logic       start_q;
  logic       loop_q;
  logic       msg_cplt_q;
  logic       halted_q;
  logic       start_pulse;
  logic       stop_pulse;
  logic       set_cplt;
  logic       in_tbl;
  fsq_pkg::fsq_state_e state_q;

  assign in_tbl = reg_addr >= fsq_pkg::ACT_TBL_BASE &&
                  reg_addr <= fsq_pkg::ACT_TBL_LAST;
  assign start_pulse = reg_wr && reg_addr == fsq_pkg::START_OFF &&
                       reg_wdata[fsq_pkg::START_BIT];
  assign stop_pulse  = reg_wr && reg_addr == fsq_pkg::START_OFF &&
                       !reg_wdata[fsq_pkg::START_BIT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) act_tbl_q[i] <= fsq_pkg::REG_RST;
    end else if (reg_wr && in_tbl) begin
      // Only the enable bit is stored; the rest reads as zero.
      act_tbl_q[reg_addr[4:0]] <=
        {7'h00, reg_wdata[fsq_pkg::ACT_EN_BIT]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      loop_cnt_q  <= fsq_pkg::REG_RST;
      instr_cnt_q <= fsq_pkg::REG_RST;
      res_lo_q    <= fsq_pkg::REG_RST;
      res_hi_q    <= fsq_pkg::REG_RST;
      ft_lo_q     <= fsq_pkg::REG_RST;
      ft_hi_q     <= fsq_pkg::REG_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        fsq_pkg::LOOP_CNT_OFF:  loop_cnt_q  <= reg_wdata;
        fsq_pkg::INSTR_CNT_OFF: instr_cnt_q <= reg_wdata;
        fsq_pkg::RES_LO_OFF:    res_lo_q    <= reg_wdata;
        fsq_pkg::RES_HI_OFF:    res_hi_q    <= reg_wdata;
        fsq_pkg::FT_LO_OFF:     ft_lo_q     <= reg_wdata;
        fsq_pkg::FT_HI_OFF:     ft_hi_q     <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      loop_q  <= 1'b0;
    end else if (start_pulse || stop_pulse) begin
      start_q <= reg_wdata[fsq_pkg::START_BIT];
      loop_q  <= reg_wdata[fsq_pkg::LOOP_BIT];
    end else if (set_cplt) begin
      start_q <= 1'b0;
    end
  end

  // Completion is sticky; a set in the same cycle as the clear wins.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      msg_cplt_q <= 1'b0;
    end else if (set_cplt) begin
      msg_cplt_q <= 1'b1;
    end else if (reg_wr && reg_addr == fsq_pkg::MSG_STATUS_OFF &&
                 reg_wdata[fsq_pkg::MSG_DONE_BIT]) begin
      msg_cplt_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      halted_q <= 1'b1;
    end else begin
      halted_q <= (state_q == fsq_pkg::ST_IDLE) && !start_pulse;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (in_tbl) begin
      reg_rdata <= act_tbl_q[reg_addr[4:0]];
    end else begin
      unique case (reg_addr)
        fsq_pkg::MSG_STATUS_OFF: reg_rdata <= {7'h00, msg_cplt_q};
        fsq_pkg::LOOP_CNT_OFF:   reg_rdata <= loop_cnt_q;
        fsq_pkg::INSTR_CNT_OFF:  reg_rdata <= instr_cnt_q;
        fsq_pkg::RES_LO_OFF:     reg_rdata <= res_lo_q;
        fsq_pkg::RES_HI_OFF:     reg_rdata <= res_hi_q;
        fsq_pkg::FT_LO_OFF:      reg_rdata <= ft_lo_q;
        fsq_pkg::FT_HI_OFF:      reg_rdata <= ft_hi_q;
        fsq_pkg::START_OFF:      reg_rdata <= {6'h00, loop_q, start_q};
        fsq_pkg::BOARD_STAT_OFF: reg_rdata <= {3'h0, halted_q, 4'h0};
        default:                 reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame timing
  // ---------------------------------------------------------------
  // The 155 ns unit is not a whole number of 4 ns cycles, so a phase
  // accumulator spreads the remainder; jitter is one cycle per unit.
  logic [7:0]  phase_q;
  logic        unit_tick;
  logic [15:0] res_cnt_q;
  logic        res_tick;
  logic [15:0] ft_cnt_q;
  logic [15:0] dead_cnt_q;
  logic        new_frame;
  logic        ft_zero;

  assign unit_tick = (phase_q >= 8'(fsq_pkg::RES_UNIT_NS -
                                    fsq_pkg::CLK_PERIOD_NS));
  assign res_tick  = unit_tick &&
                     (res_cnt_q + 16'h0001 >= pair16(res_hi_q, res_lo_q));
  assign ft_zero   = (ft_cnt_q == 16'h0000);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || new_frame) begin
      phase_q <= 8'h00;
    end else if (unit_tick) begin
      phase_q <= phase_q + 8'(fsq_pkg::CLK_PERIOD_NS) -
                 8'(fsq_pkg::RES_UNIT_NS);
    end else begin
      phase_q <= phase_q + 8'(fsq_pkg::CLK_PERIOD_NS);
    end
  end

  // A resolution of zero behaves as one.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || new_frame || res_tick) begin
      res_cnt_q <= 16'h0000;
    end else if (unit_tick) begin
      res_cnt_q <= res_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ft_cnt_q <= 16'h0000;
    end else if (new_frame) begin
      ft_cnt_q <= pair16(ft_hi_q, ft_lo_q);
    end else if (res_tick && !ft_zero) begin
      ft_cnt_q <= ft_cnt_q - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  logic [7:0] issued_q;
  logic [7:0] done_q;
  logic [7:0] pass_q;
  logic       gap_ok;
  logic       last_pass;
  logic       push;
  fsq_stream_if #(.W(8)) q_in ();
  fsq_stream_if #(.W(8)) q_out ();

  assign new_frame = (state_q == fsq_pkg::ST_IDLE && start_pulse) ||
                     (state_q == fsq_pkg::ST_GAP && gap_ok && start_q);
  // Frame time and bus dead time must both have run out.
  assign gap_ok    = ft_zero && dead_cnt_q == 16'h0000;
  // Loop bit with count zero means run until stopped.
  assign last_pass = !loop_q || (loop_cnt_q != 8'h00 &&
                                 pass_q + 8'h01 >= loop_cnt_q);
  assign set_cplt  = state_q == fsq_pkg::ST_DRAIN &&
                     done_q == instr_cnt_q && last_pass;
  assign push      = q_in.valid && q_in.ready;
  assign q_in.valid = (state_q == fsq_pkg::ST_ISSUE) &&
                      (issued_q != instr_cnt_q);
  assign q_in.data  = issued_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= fsq_pkg::ST_IDLE;
    end else if (stop_pulse) begin
      state_q <= fsq_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        fsq_pkg::ST_IDLE:
          if (start_pulse) state_q <= fsq_pkg::ST_ISSUE;
        fsq_pkg::ST_ISSUE:
          if (issued_q == instr_cnt_q) state_q <= fsq_pkg::ST_DRAIN;
        fsq_pkg::ST_DRAIN:
          if (done_q == instr_cnt_q) begin
            // One pass then idle unless looping.
            state_q <= last_pass ? fsq_pkg::ST_IDLE : fsq_pkg::ST_GAP;
          end
        fsq_pkg::ST_GAP:
          if (gap_ok) state_q <= fsq_pkg::ST_ISSUE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || new_frame) begin
      issued_q <= 8'h00;
      done_q   <= 8'h00;
    end else begin
      if (push) issued_q <= issued_q + 8'h01;
      if (msg_done && state_q != fsq_pkg::ST_IDLE) begin
        done_q <= done_q + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || (state_q == fsq_pkg::ST_IDLE && start_pulse)) begin
      pass_q <= 8'h00;
    end else if (state_q == fsq_pkg::ST_DRAIN && done_q == instr_cnt_q) begin
      pass_q <= pass_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dead_cnt_q <= 16'h0000;
    end else if (state_q == fsq_pkg::ST_DRAIN && done_q == instr_cnt_q) begin
      dead_cnt_q <= 16'(DEAD_CYC);
    end else if (dead_cnt_q != 16'h0000) begin
      dead_cnt_q <= dead_cnt_q - 16'h0001;
    end
  end

  fsq_buf2 #(.W(8)) u_buf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .in_s    (q_in.snk),
    .out_s   (q_out.src)
  );

  assign msg_valid   = q_out.valid;
  assign msg_index   = q_out.data;
  assign q_out.ready = msg_ready;
  assign frame_busy  = (state_q != fsq_pkg::ST_IDLE);

  // ---------------------------------------------------------------
  // Terminal lookup and mode decode
  // ---------------------------------------------------------------
  logic [4:0] mode_code;
  assign mode_code = cmd_word[4:0];
  assign rt_sim    = act_tbl_q[cmd_word[15:11]][fsq_pkg::ACT_EN_BIT];
  // Word-count field carries the mode code under subaddress 0 or 31.
  assign mode_is_code  = is_mode(cmd_word);
  assign mode_has_data = is_mode(cmd_word) &&
                         mode_code[fsq_pkg::MODE_DATA_BIT];
  assign mode_unsupported = is_mode(cmd_word) &&
                            (mode_code == fsq_pkg::MODE_SHUTDN ||
                             mode_code == fsq_pkg::MODE_OVRIDE);

  // ---------------------------------------------------------------
  // Storage of words from real terminals
  // ---------------------------------------------------------------
  // Words arrive in bus order and are stored in that order after the
  // command words, so the block ends up as the bus saw it. A simulated
  // receiver's status is host-loaded and is not overwritten.
  logic [15:0] cursor_q;
  logic        store_ok;
  assign store_ok = rx_valid && !(msg_kind == fsq_pkg::KIND_RX && rt_sim);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cursor_q <= 16'h0000;
    end else if (msg_start) begin
      // Transmit skips control+command; RT-to-RT skips control+two commands.
      cursor_q <= msg_base + ((msg_kind == fsq_pkg::KIND_RTRT) ?
                              16'h0003 : 16'h0002);
    end else if (store_ok) begin
      cursor_q <= cursor_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else begin
      mem_we    <= store_ok;
      mem_addr  <= cursor_q;
      mem_wdata <= rx_word;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_frame_end;
    state_q == fsq_pkg::ST_DRAIN && done_q == instr_cnt_q;
  endsequence

  tbl_high_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && in_tbl |=> reg_rdata[7:1] == 7'h00)
    else $error("table byte upper bits not zero");
  single_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_frame_end and !loop_q |=> state_q == fsq_pkg::ST_IDLE
      && msg_cplt_q)
    else $error("single pass did not end with completion");
  loop_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_frame_end and !last_pass && !stop_pulse
      |=> state_q == fsq_pkg::ST_GAP)
    else $error("loop did not enter gap");
  ft_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    new_frame && !stop_pulse |=> ft_cnt_q == $past(pair16(ft_hi_q,
      ft_lo_q)))
    else $error("frame counter not loaded");
  gap_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == fsq_pkg::ST_GAP && !ft_zero && !stop_pulse
      |=> state_q == fsq_pkg::ST_GAP)
    else $error("frame started before counter zero");
  dead_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_frame_end and !last_pass |=> dead_cnt_q == 16'(DEAD_CYC))
    else $error("dead time not armed");
  ft_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !new_frame && !res_tick |=> $stable(ft_cnt_q))
    else $error("frame counter moved without a tick");
  shutdown_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_mode(cmd_word) && cmd_word[4:0] == 5'h14 |-> mode_unsupported)
    else $error("shutdown mode code accepted");
  start_go_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == fsq_pkg::ST_IDLE && start_pulse
      |=> state_q == fsq_pkg::ST_ISSUE ##1 !halted_q)
    else $error("start did not begin transfers");
  store_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    store_ok && !msg_start |=> mem_we && mem_addr == $past(cursor_q))
    else $error("returned word not stored at cursor");
endmodule : fsq_frame_sched
`default_nettype wire

/* File: core/fsq_pkg.sv */
/*
  Constants for the frame scheduler: register offsets, field positions,
  reset values, states, message kinds and timing figures.
  Assumes a 250 MHz system clock and an 8-bit register port.
*/
`default_nettype none
package fsq_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [13:0] ACT_TBL_BASE   = 14'h3400;
  localparam logic [13:0] ACT_TBL_LAST   = 14'h341F;
  localparam logic [13:0] MSG_STATUS_OFF = 14'h3FE0;
  localparam logic [13:0] LOOP_CNT_OFF   = 14'h3FE1;
  localparam logic [13:0] INSTR_CNT_OFF  = 14'h3FEB;
  localparam logic [13:0] RES_LO_OFF     = 14'h3FEC;
  localparam logic [13:0] RES_HI_OFF     = 14'h3FED;
  localparam logic [13:0] FT_LO_OFF      = 14'h3FEE;
  localparam logic [13:0] FT_HI_OFF      = 14'h3FEF;
  localparam logic [13:0] START_OFF      = 14'h3FFC;
  localparam logic [13:0] BOARD_STAT_OFF = 14'h3FFD;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int START_BIT     = 0;
  localparam int LOOP_BIT      = 1;
  localparam int MSG_DONE_BIT  = 0;
  localparam int HALTED_BIT    = 4;
  localparam int ACT_EN_BIT    = 0;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [7:0] BOARD_IDLE  = 8'h10;
  localparam logic [4:0] MODE_SHUTDN = 5'h14;
  localparam logic [4:0] MODE_OVRIDE = 5'h15;
  localparam int MODE_DATA_BIT = 4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RES_UNIT_NS   = 155;
  localparam int DEAD_TIME_NS  = 20000;
  localparam int DEAD_CYCLES   =
    (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_DRAIN = 2'b10,
    ST_GAP   = 2'b11
  } fsq_state_e;

  typedef enum logic [1:0] {
    KIND_TX   = 2'b00,
    KIND_RX   = 2'b01,
    KIND_RTRT = 2'b10,
    KIND_MODE = 2'b11
  } fsq_kind_e;
endpackage : fsq_pkg
`default_nettype wire

/* File: core/fsq_stream_if.sv */
/*
  Valid/ready carrier for message indices between scheduler and buffer.
  Assumes both ends share the system clock.
*/
`default_nettype none
interface fsq_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fsq_stream_if
`default_nettype wire
